// *** rtl/rss_consts.svh ***
// Offsets, field positions, reset values and timing counts of the reset supervisor
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// Register addresses on the special function register port
`define RSS_ADDR_SUPPLY      8'hFF
`define RSS_ADDR_CAUSE       8'hEF

// Supply monitor control fields
`define RSS_S_DIG_MON_EN     7
`define RSS_S_DIG_ABOVE_RST  6
`define RSS_S_DIG_ABOVE_WARN 5
`define RSS_S_DIG_IRQ_EN     4
`define RSS_S_BAT_MON_EN     3
`define RSS_S_BAT_ABOVE_RST  2
`define RSS_S_BAT_ABOVE_WARN 1
`define RSS_S_BAT_IRQ_EN     0

// Reset cause register fields
`define RSS_C_RTC            7
`define RSS_C_FLASH          6
`define RSS_C_CMP            5
`define RSS_C_SW             4
`define RSS_C_WDT            3
`define RSS_C_MCD            2
`define RSS_C_POR            1
`define RSS_C_PIN            0

// Reset values
`define RSS_CAUSE_POR_ONLY   8'h02
`define RSS_RDATA_RESET      8'h00

// Timing
`define RSS_CLK_PERIOD_NS    5
`define RSS_MCD_TIME_NS      100000
`define RSS_WDT_DIV          12
`define RSS_HOLD_CYCLES      8

`endif

// *** rtl/rss_pkg.sv ***
// Types shared by the reset supervisor files
package rss_pkg;

  // Cause flags, bit 7 down to bit 0 as software reads them
  typedef struct packed {
    logic rtc;
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic clock_loss_detector;
    logic por;
    logic pin;
  } rss_cause_t;

  // Flash access faults, one-cycle pulses from the flash controller
  typedef struct packed {
    logic wr_beyond;
    logic rd_beyond;
    logic branch_beyond;
    logic security_block;
    logic wr_attempt;
  } rss_flash_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    RSS_RUN  = 2'b01,
    RSS_HOLD = 2'b10
  } rss_state_t;

endpackage : rss_pkg

// *** rtl/rss_sync.sv ***
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
module rss_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : rss_sync

// *** rtl/rss_watchdog.sv ***
// Watchdog timer ticking at the system clock divided by twelve
`timescale 1ns/100ps
`include "rss_consts.svh"
module rss_watchdog #(
  parameter int DIV   = `RSS_WDT_DIV,
  parameter int LIMIT = 256
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic disable_sw,
  input  wire logic kick,
  output logic      expire
);

  localparam int DW = $clog2(DIV);
  localparam int CW = $clog2(LIMIT + 1);

  logic [DW-1:0] div_r;
  logic [CW-1:0] cnt_r;
  logic          tick;

  assign tick = (div_r == DW'(DIV - 1));

  // Divider makes the one-cycle tick enable
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      div_r <= '0;
    end else begin
      div_r <= tick ? '0 : div_r + 1'b1;
    end
  end

  // Counter restarts enabled after every reset; stopped in low power
  always_ff @(posedge clock) begin
    if (rst || kick || disable_sw) begin
      cnt_r  <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (run && tick) begin
        if (cnt_r == CW'(LIMIT - 1)) begin
          cnt_r  <= '0;
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule : rss_watchdog

// *** rtl/rss_supervisor.sv ***
// Reset source supervisor: gathers reset requests, records causes, supply monitor control
`timescale 1ns/100ps
`include "rss_consts.svh"

module rss_supervisor #(
  parameter int MCD_CYCLES = `RSS_MCD_TIME_NS / `RSS_CLK_PERIOD_NS,
  parameter int WDT_LIMIT  = 256
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [7:0]              sfr_addr,
  input  wire logic                    sfr_wr,
  input  wire logic [7:0]              sfr_wdata,
  output logic      [7:0]              sfr_rdata,
  input  wire logic                    reset_pin_n_in,
  output logic                         reset_pin_out,
  output logic                         reset_pin_oe_n,
  input  wire logic                    dig_above_reset_in,
  input  wire logic                    dig_above_warn_in,
  input  wire logic                    bat_above_reset_in,
  input  wire logic                    bat_above_warn_in,
  input  wire logic                    clock_monitor_in,
  input  wire logic                    cmp_above_in,
  input  wire logic                    rtc_alarm_in,
  input  wire logic                    rtc_osc_fail_in,
  input  wire logic                    low_power,
  input  wire logic                    cmp_wake_enable,
  input  wire logic                    wd_kick,
  input  wire logic                    wd_disable,
  input  wire rss_pkg::rss_flash_req_t flash_req,
  output logic                         sys_rst,
  output logic                         dig_warn_irq,
  output logic                         bat_warn_irq
);

  localparam int MW = $clog2(MCD_CYCLES + 1);

  rss_pkg::rss_state_t state_r;
  rss_pkg::rss_cause_t flags_r;
  rss_pkg::rss_cause_t req;
  logic [7:0]          pins_sync;
  logic                pin_n_s, dig_rst_s, dig_warn_s, bat_rst_s;
  logic                bat_warn_s, clk_mon_s, cmp_s, rtc_evt_s;
  logic                dig_mon_en_r, dig_irq_en_r, bat_mon_en_r, bat_irq_en_r;
  logic                rtc_en_r, cmp_en_r, mcd_en_r, por_en_r;
  logic                hold_power_r, clk_mon_d_r, wd_expire;
  logic [MW-1:0]       mcd_cnt_r;
  logic [3:0]          hold_cnt_r;
  logic                wr_cause, wr_supply, power_req, level_busy;

  // Decoding shared by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  assign wr_cause  = sfr_wr && hit(sfr_addr, `RSS_ADDR_CAUSE);
  assign wr_supply = sfr_wr && hit(sfr_addr, `RSS_ADDR_SUPPLY);

  // Every off-domain level passes two flops; pin idles high
  rss_sync #(
    .W       (8),
    .RST_VAL (8'h6F)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({clock_monitor_in, dig_above_reset_in, dig_above_warn_in,
             rtc_alarm_in | rtc_osc_fail_in, bat_above_reset_in,
             bat_above_warn_in, cmp_above_in, reset_pin_n_in}),
    .q     (pins_sync)
  );

  assign clk_mon_s  = pins_sync[7];
  assign dig_rst_s  = pins_sync[6];
  assign dig_warn_s = pins_sync[5];
  assign rtc_evt_s  = pins_sync[4];
  assign bat_rst_s  = pins_sync[3];
  assign bat_warn_s = pins_sync[2];
  assign cmp_s      = pins_sync[1];
  assign pin_n_s    = pins_sync[0];

  // Watchdog restarts on any reset and pauses in low power
  rss_watchdog #(
    .DIV   (`RSS_WDT_DIV),
    .LIMIT (WDT_LIMIT)
  ) u_wdt (
    .clock      (clock),
    .rst        (rst || sys_rst),
    .run        (!low_power),
    .disable_sw (wd_disable),
    .kick       (wd_kick),
    .expire     (wd_expire)
  );

  // Stuck-clock one-shot; counter freezes at zero when paused
  always_ff @(posedge clock) begin
    if (rst || sys_rst || !mcd_en_r || low_power) begin
      mcd_cnt_r   <= '0;
      clk_mon_d_r <= clk_mon_s;
    end else begin
      clk_mon_d_r <= clk_mon_s;
      if (clk_mon_s != clk_mon_d_r) begin
        mcd_cnt_r <= '0;
      end else if (mcd_cnt_r != MW'(MCD_CYCLES)) begin
        mcd_cnt_r <= mcd_cnt_r + 1'b1;
      end
    end
  end

  // Power-fail: monitor must be enabled and selected; sleep turns it off
  assign power_req = !low_power && por_en_r &&
                     ((dig_mon_en_r && !dig_rst_s) || (bat_mon_en_r && !bat_rst_s));

  // Request vector, one bit per cause
  always_comb begin
    req       = '0;
    req.pin   = !pin_n_s && hold_power_r == 1'b0;
    req.por   = power_req;
    req.clock_loss_detector   = (mcd_cnt_r == MW'(MCD_CYCLES));
    req.wdt   = wd_expire;
    req.sw    = wr_cause && sfr_wdata[`RSS_C_SW];
    req.cmp   = cmp_en_r && !cmp_s && (!low_power || cmp_wake_enable);
    req.flash = flash_req.wr_beyond || flash_req.rd_beyond ||
                flash_req.branch_beyond || flash_req.security_block ||
                (flash_req.wr_attempt && !dig_mon_en_r);
    req.rtc   = rtc_en_r && rtc_evt_s;
  end

  // Pin, power-fail and comparator levels keep the reset held past the minimum pulse
  assign level_busy = req.pin || req.por || req.cmp;

  // Sequencer: one synchronous reset for every cause
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r      <= rss_pkg::RSS_HOLD;
      hold_cnt_r   <= 4'(`RSS_HOLD_CYCLES - 1);
      sys_rst      <= 1'b1;
      hold_power_r <= 1'b1;
    end else begin
      unique case (state_r)
        rss_pkg::RSS_RUN: begin
          if (|req) begin
            state_r      <= rss_pkg::RSS_HOLD;
            hold_cnt_r   <= 4'(`RSS_HOLD_CYCLES - 1);
            sys_rst      <= 1'b1;
            hold_power_r <= req.por;
          end else if (pin_n_s) begin
            hold_power_r <= 1'b0;
          end
        end
        rss_pkg::RSS_HOLD: begin
          if (hold_cnt_r != 4'h0) begin
            hold_cnt_r <= hold_cnt_r - 1'b1;
          end else if (!level_busy) begin
            state_r      <= rss_pkg::RSS_RUN;
            sys_rst      <= 1'b0;
            // Own pin drive is still in the synchroniser; a late pin low is missed
            hold_power_r <= hold_power_r && !pin_n_s;
          end
        end
      endcase
    end
  end

  // Pin driven low only for power resets; always driving value zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reset_pin_oe_n <= 1'b0;
      reset_pin_out  <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      if (state_r == rss_pkg::RSS_RUN) begin
        reset_pin_oe_n <= !req.por;
      end else if (hold_cnt_r == 4'h0 && !level_busy) begin
        reset_pin_oe_n <= 1'b1;
      end
    end
  end

  // Cause capture; a power reset reports only its own bit
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= rss_pkg::rss_cause_t'(`RSS_CAUSE_POR_ONLY);
    end else if (state_r == rss_pkg::RSS_RUN && |req) begin
      if (req.por) begin
        flags_r <= rss_pkg::rss_cause_t'(`RSS_CAUSE_POR_ONLY);
      end else begin
        flags_r <= req;
      end
    end
  end

  // Source selections: defaults only on power resets
  always_ff @(posedge clock) begin
    if (rst || (state_r == rss_pkg::RSS_RUN && req.por)) begin
      dig_mon_en_r <= 1'b1;
      bat_mon_en_r <= 1'b0;
      por_en_r     <= 1'b1;
      mcd_en_r     <= 1'b0;
      cmp_en_r     <= 1'b0;
      rtc_en_r     <= 1'b0;
    end else if (!sys_rst) begin
      if (wr_supply) begin
        dig_mon_en_r <= sfr_wdata[`RSS_S_DIG_MON_EN];
        bat_mon_en_r <= sfr_wdata[`RSS_S_BAT_MON_EN];
      end
      if (wr_cause) begin
        rtc_en_r <= sfr_wdata[`RSS_C_RTC];
        cmp_en_r <= sfr_wdata[`RSS_C_CMP];
        mcd_en_r <= sfr_wdata[`RSS_C_MCD];
        por_en_r <= sfr_wdata[`RSS_C_POR];
      end
    end
  end

  // Interrupt enables clear on every system reset
  always_ff @(posedge clock) begin
    if (rst || sys_rst) begin
      dig_irq_en_r <= 1'b0;
      bat_irq_en_r <= 1'b0;
    end else if (wr_supply) begin
      dig_irq_en_r <= sfr_wdata[`RSS_S_DIG_IRQ_EN];
      bat_irq_en_r <= sfr_wdata[`RSS_S_BAT_IRQ_EN];
    end
  end

  // Early-warning interrupts are levels while the supply sags
  always_ff @(posedge clock) begin
    if (rst || sys_rst) begin
      dig_warn_irq <= 1'b0;
      bat_warn_irq <= 1'b0;
    end else begin
      dig_warn_irq <= dig_irq_en_r && !dig_warn_s;
      bat_warn_irq <= bat_irq_en_r && bat_mon_en_r && !bat_warn_s;
    end
  end

  // Read data, one cycle after the address; battery status zero when off
  always_ff @(posedge clock) begin
    if (rst) begin
      sfr_rdata <= `RSS_RDATA_RESET;
    end else if (hit(sfr_addr, `RSS_ADDR_SUPPLY)) begin
      sfr_rdata <= '0;
      sfr_rdata[`RSS_S_DIG_MON_EN]     <= dig_mon_en_r;
      sfr_rdata[`RSS_S_DIG_ABOVE_RST]  <= dig_rst_s;
      sfr_rdata[`RSS_S_DIG_ABOVE_WARN] <= dig_warn_s;
      sfr_rdata[`RSS_S_DIG_IRQ_EN]     <= dig_irq_en_r;
      sfr_rdata[`RSS_S_BAT_MON_EN]     <= bat_mon_en_r;
      sfr_rdata[`RSS_S_BAT_ABOVE_RST]  <= bat_mon_en_r && bat_rst_s;
      sfr_rdata[`RSS_S_BAT_ABOVE_WARN] <= bat_mon_en_r && bat_warn_s;
      sfr_rdata[`RSS_S_BAT_IRQ_EN]     <= bat_irq_en_r;
    end else if (hit(sfr_addr, `RSS_ADDR_CAUSE)) begin
      sfr_rdata <= flags_r;
    end else begin
      sfr_rdata <= '0;
    end
  end

  // Checks on the reset path
  sequence s_run_req;
    state_r == rss_pkg::RSS_RUN && |req;
  endsequence

  property p_merge;
    @(posedge clock) disable iff (rst) s_run_req |=> sys_rst ##0 state_r == rss_pkg::RSS_HOLD;
  endproperty
  a_merge: assert property (p_merge) else $error("request did not start reset");

  property p_sw;
    @(posedge clock) disable iff (rst)
      (state_r == rss_pkg::RSS_RUN && wr_cause && sfr_wdata[`RSS_C_SW] && !power_req)
      |=> flags_r.sw && sys_rst;
  endproperty
  a_sw: assert property (p_sw) else $error("software reset not taken");

  property p_pin_quiet;
    @(posedge clock) disable iff (rst) sys_rst && !hold_power_r |-> reset_pin_oe_n;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("pin driven on internal reset");

  property p_mcd;
    @(posedge clock) disable iff (rst)
      (state_r == rss_pkg::RSS_RUN && req.clock_loss_detector && !req.por) |=> flags_r.clock_loss_detector ##0 sys_rst;
  endproperty
  a_mcd: assert property (p_mcd) else $error("clock loss not recorded");

  property p_mcd_pause;
    @(posedge clock) disable iff (rst) low_power |=> mcd_cnt_r == '0;
  endproperty
  a_mcd_pause: assert property (p_mcd_pause) else $error("clock detector ran in low power");

  property p_cmp_sleep;
    @(posedge clock) disable iff (rst) low_power && !cmp_wake_enable |-> !req.cmp;
  endproperty
  a_cmp_sleep: assert property (p_cmp_sleep) else $error("comparator reset in sleep");

  property p_keep_sel;
    @(posedge clock) disable iff (rst)
      $rose(sys_rst) && !hold_power_r |-> $stable(dig_mon_en_r) ##1 $stable(por_en_r);
  endproperty
  a_keep_sel: assert property (p_keep_sel) else $error("selection lost on warm reset");

  property p_flash_nomon;
    @(posedge clock) disable iff (rst)
      (state_r == rss_pkg::RSS_RUN && flash_req.wr_attempt && !dig_mon_en_r && !power_req)
      |=> flags_r.flash;
  endproperty
  a_flash_nomon: assert property (p_flash_nomon) else $error("flash fault missed");

  property p_por_flag;
    @(posedge clock) disable iff (rst)
      (state_r == rss_pkg::RSS_RUN && req.por) |=> flags_r.por ##0 dig_mon_en_r ##0 !reset_pin_oe_n;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-fail reset wrong");

  property p_hold_min;
    @(posedge clock) disable iff (rst) $rose(sys_rst) |-> sys_rst [*8];
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset pulse too short");

endmodule : rss_supervisor

// *** test/rss_far_model.sv ***
// Far side model: pulled-up reset pin, watched clock, comparator 0
`timescale 1ns/100ps
module rss_far_model (
  input  wire logic clock,
  input  wire logic ext_low,
  input  wire logic stall,
  input  wire logic cmp_low,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe_n,
  output logic      pin_level,
  output logic      clock_mon,
  output logic      cmp_above
);
  // Pull-up wins unless the device or an outside party pulls low
  assign pin_level = reset_pin_oe_n ? !ext_low : reset_pin_out;
  // Settled comparator, high unless told to dip
  assign cmp_above = !cmp_low;
  // Watched clock toggles each cycle, frozen at one level when stalled
  initial clock_mon = 1'b0;
  always @(posedge clock) begin
    if (!stall) begin
      clock_mon <= !clock_mon;
    end
  end
endmodule : rss_far_model

// *** test/tb.sv ***
// Self-checking bench for the reset source supervisor
`timescale 1ns/100ps
`include "rss_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
$display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  localparam int MCD_N = 50;
  localparam int WDT_N = 4;
  logic       clock, rst, sfr_wr, reset_pin_n_in, reset_pin_out, reset_pin_oe_n, sys_rst;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic       dig_above_reset_in, dig_above_warn_in, bat_above_reset_in, bat_above_warn_in;
  logic       clock_monitor_in, cmp_above_in, rtc_alarm_in, rtc_osc_fail_in, low_power;
  logic       cmp_wake_enable, wd_kick, wd_disable, dig_warn_irq, bat_warn_irq;
  logic       ext_low, stall, cmp_low, auto_kick, hit, drove;
  logic [3:0] kick_cnt = 4'h0;
  int         err_total, samples_checked, cycles;
  rss_pkg::rss_flash_req_t flash_req;

  rss_supervisor #(.MCD_CYCLES(MCD_N), .WDT_LIMIT(WDT_N)) dut (
    .clock, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .reset_pin_n_in,
    .reset_pin_out, .reset_pin_oe_n, .dig_above_reset_in, .dig_above_warn_in,
    .bat_above_reset_in, .bat_above_warn_in, .clock_monitor_in, .cmp_above_in,
    .rtc_alarm_in, .rtc_osc_fail_in, .low_power, .cmp_wake_enable, .wd_kick,
    .wd_disable, .flash_req, .sys_rst, .dig_warn_irq, .bat_warn_irq);
  rss_far_model far (.clock, .ext_low, .stall, .cmp_low, .reset_pin_out, .reset_pin_oe_n,
    .pin_level(reset_pin_n_in), .clock_mon(clock_monitor_in), .cmp_above(cmp_above_in));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Background watchdog service every 16 cycles; ceiling cuts a hang short
  always @(posedge clock) begin
    kick_cnt <= kick_cnt + 4'h1;
    wd_kick  <= auto_kick && (kick_cnt == 4'h0);
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      conclude();
    end
  end
  // Sticky observers, sampled mid-cycle where outputs have settled
  always @(negedge clock) begin
    if (sys_rst === 1'b1) hit = 1'b1;
    if (reset_pin_oe_n === 1'b0) drove = 1'b1;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Register port cycles; every helper returns on a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
  endtask : wr
  // Extra edge covers the input synchroniser ahead of the read register
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    sfr_addr <= a;
    repeat (3) @(posedge clock);
    @(negedge clock);
    v = sfr_rdata;
    @(posedge clock);
  endtask : rd
  task automatic idle(input int n);
    hit = 1'b0;
    repeat (n) @(negedge clock);
    `CHK(hit, 1'b0)
    @(posedge clock);
  endtask : idle
  task automatic rst_on();
    int n;
    n = 0;
    drove = 1'b0;
    while (sys_rst !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    `CHK(sys_rst, 1'b1)
    @(posedge clock);
  endtask : rst_on
  task automatic rst_off(input logic [7:0] m, input logic [7:0] e, input logic d);
    int n;
    n = 0;
    while (sys_rst !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    `CHK(sys_rst, 1'b0)
    `CHK(drove, d)
    `CHK(reset_pin_out, 1'b0)
    rd(`RSS_ADDR_CAUSE);
    `CHK(v & m, e)
  endtask : rst_off
  task automatic pulse(input logic [4:0] f);
    @(posedge clock);
    flash_req <= rss_pkg::rss_flash_req_t'(f);
    @(posedge clock);
    flash_req <= '0;
  endtask : pulse

  // Scenarios, each judging its own outcome
  task automatic t_regs();
    rd(`RSS_ADDR_SUPPLY);
    `CHK(v, 8'hE0)
    wr(`RSS_ADDR_SUPPLY, 8'h99);
    rd(`RSS_ADDR_SUPPLY);
    `CHK(v, 8'hFF)
    // Deselect power-fail so a low battery only shows in status
    wr(`RSS_ADDR_CAUSE, 8'h00);
    dig_above_warn_in  <= 1'b0;
    bat_above_reset_in <= 1'b0;
    rd(`RSS_ADDR_SUPPLY);
    `CHK({v, dig_warn_irq, bat_warn_irq}, 10'h36E)
    bat_above_warn_in <= 1'b0;
    rd(`RSS_ADDR_SUPPLY);
    `CHK({v, bat_warn_irq}, 9'h1B3)
    {dig_above_warn_in, bat_above_reset_in, bat_above_warn_in} <= 3'h7;
    rd(8'h00);
    `CHK(v, 8'h00)
    $display("test regs done");
  endtask : t_regs
  task automatic t_sw();
    wr(`RSS_ADDR_CAUSE, 8'h12);
    rst_on();
    rst_off(8'hFF, 8'h10, 1'b0);
    rd(`RSS_ADDR_SUPPLY);
    `CHK(v, 8'hEE)
    low_power <= 1'b1;
    ext_low   <= 1'b1;
    rst_on();
    {ext_low, low_power} <= 2'h0;
    rst_off(8'hFF, 8'h01, 1'b0);
    $display("test software and pin done");
  endtask : t_sw
  task automatic t_mcd();
    wr(`RSS_ADDR_CAUSE, 8'h06);
    {low_power, stall} <= 2'h3;
    idle(MCD_N + 30);
    {low_power, stall} <= 2'h0;
    idle(4);
    stall <= 1'b1;
    idle(MCD_N - 5);
    rst_on();
    stall <= 1'b0;
    rst_off(8'hFF, 8'h04, 1'b0);
    $display("test clock loss done");
  endtask : t_mcd
  task automatic t_cmp();
    wr(`RSS_ADDR_CAUSE, 8'h22);
    {low_power, cmp_low} <= 2'h3;
    idle(20);
    cmp_wake_enable <= 1'b1;
    rst_on();
    {low_power, cmp_low, cmp_wake_enable} <= 3'h0;
    rst_off(8'hFF, 8'h20, 1'b0);
    $display("test comparator done");
  endtask : t_cmp
  task automatic t_wdt();
    wd_disable <= 1'b1;
    auto_kick  <= 1'b0;
    idle(150);
    {wd_disable, auto_kick} <= 2'h1;
    idle(150);
    {low_power, auto_kick} <= 2'h2;
    idle(150);
    low_power <= 1'b0;
    rst_on();
    rst_off(8'hFF, 8'h08, 1'b0);
    idle(WDT_N * 12 - 20);
    rst_on();
    auto_kick <= 1'b1;
    rst_off(8'hFF, 8'h08, 1'b0);
    $display("test watchdog done");
  endtask : t_wdt
  task automatic t_flash();
    pulse(5'h01);
    idle(20);
    for (int i = 0; i < 5; i++) begin
      if (i == 0) wr(`RSS_ADDR_SUPPLY, 8'h00);
      pulse(5'(1 << i));
      rst_on();
      rst_off(8'hFF, 8'h40, 1'b0);
      wr(`RSS_ADDR_SUPPLY, 8'h80);
    end
    $display("test flash done");
  endtask : t_flash
  task automatic t_rtc();
    wr(`RSS_ADDR_CAUSE, 8'h02);
    rtc_alarm_in <= 1'b1;
    idle(20);
    rtc_alarm_in <= 1'b0;
    idle(4);
    for (int j = 0; j < 2; j++) begin
      wr(`RSS_ADDR_CAUSE, 8'h82);
      {low_power, rtc_alarm_in, rtc_osc_fail_in} <= {1'b1, j == 0, j == 1};
      rst_on();
      {rtc_alarm_in, rtc_osc_fail_in, low_power} <= 3'h0;
      rst_off(8'hFF, 8'h80, 1'b0);
    end
    $display("test rtc done");
  endtask : t_rtc
  task automatic t_pfail();
    wr(`RSS_ADDR_SUPPLY, 8'h88);
    wr(`RSS_ADDR_CAUSE, 8'h00);
    dig_above_reset_in <= 1'b0;
    idle(20);
    rd(`RSS_ADDR_SUPPLY);
    `CHK(v, 8'hAE)
    wr(`RSS_ADDR_CAUSE, 8'h02);
    rst_on();
    dig_above_reset_in <= 1'b1;
    rst_off(8'h02, 8'h02, 1'b1);
    rd(`RSS_ADDR_SUPPLY);
    `CHK(v & 8'h88, 8'h80)
    $display("test power fail done");
  endtask : t_pfail

  // Main sequence
  initial begin
    {sfr_wr, ext_low, stall, cmp_low, rtc_alarm_in, rtc_osc_fail_in, low_power} = '0;
    {cmp_wake_enable, wd_disable, hit, drove} = '0;
    {rst, auto_kick, dig_above_reset_in, dig_above_warn_in} = '1;
    {bat_above_reset_in, bat_above_warn_in} = '1;
    {sfr_addr, sfr_wdata} = '0;
    flash_req = '0;
    {err_total, samples_checked, cycles} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rst_off(8'hFF, `RSS_CAUSE_POR_ONLY, 1'b1);
    t_regs();
    t_sw();
    t_mcd();
    t_cmp();
    t_wdt();
    t_flash();
    t_rtc();
    t_pfail();
    conclude();
  end
endmodule : tb
